/* File: common/mie_pkg.sv */
// Package of constants, opcodes and register map for the instruction execute block
package mie_pkg;
  // APB register byte offsets
  localparam logic [7:0] MIE_OFF_CMD = 8'h00;
  localparam logic [7:0] MIE_OFF_ACC = 8'h04;
  localparam logic [7:0] MIE_OFF_FLAGS = 8'h08;
  localparam logic [7:0] MIE_OFF_PC = 8'h0C;
  localparam logic [7:0] MIE_OFF_MEM = 8'h10;
  localparam logic [7:0] MIE_OFF_STAT = 8'h14;
  localparam logic [7:0] MIE_OFF_WDT = 8'h18;
  localparam logic [7:0] MIE_OFF_SP = 8'h1C;
  // Command word field positions
  localparam int MIE_CMD_OP_LSB = 0;
  localparam int MIE_CMD_ADDR_LSB = 8;
  localparam int MIE_CMD_IMM_LSB = 16;
  localparam int MIE_CMD_TGT_LSB = 16;
  // Flag register bit positions
  localparam int MIE_FLG_C = 0;
  localparam int MIE_FLG_HALF = 1;
  localparam int MIE_FLG_Z = 2;
  localparam int MIE_FLG_OV = 3;
  localparam int MIE_FLG_SLEEP = 4;
  localparam int MIE_FLG_WDX = 5;
  localparam int MIE_FLG_GIE = 6;
  // Reset values
  localparam logic [7:0] MIE_RST_ACC = 8'h00;
  localparam logic [6:0] MIE_RST_FLAGS = 7'h00;
  localparam logic [10:0] MIE_RST_PC = 11'h000;
  // Timing: system clocks per instruction cycle
  localparam int MIE_CLK_PER_CYC = 4;
  localparam logic [1:0] MIE_PH_LAST = 2'(MIE_CLK_PER_CYC - 1);
  // Instruction codes on the command port
  typedef enum logic [7:0] {
    MIE_OP_IDLE = 8'h00,
    MIE_OP_INV_MEM = 8'h01,
    MIE_OP_INV_ACC = 8'h02,
    MIE_OP_BCD = 8'h03,
    MIE_OP_SUB1_MEM = 8'h04,
    MIE_OP_SUB1_ACC = 8'h05,
    MIE_OP_INC_MEM = 8'h06,
    MIE_OP_INC_ACC = 8'h07,
    MIE_OP_SLEEP = 8'h08,
    MIE_OP_GOTO = 8'h09,
    MIE_OP_COPY_A_M = 8'h0A,
    MIE_OP_COPY_M_A = 8'h0B,
    MIE_OP_COPY_A_X = 8'h0C,
    MIE_OP_OR_A_M = 8'h0D,
    MIE_OP_OR_A_X = 8'h0E,
    MIE_OP_OR_MEM = 8'h0F,
    MIE_OP_POP = 8'h10,
    MIE_OP_POP_X = 8'h11,
    MIE_OP_IRET = 8'h12,
    MIE_OP_ROTL_MEM = 8'h13,
    MIE_OP_ROTL_ACC = 8'h14,
    MIE_OP_ROTLC_MEM = 8'h15,
    MIE_OP_ROTLC_ACC = 8'h16,
    MIE_OP_ROTR_MEM = 8'h17,
    MIE_OP_ROTR_ACC = 8'h18,
    MIE_OP_ROTRC_MEM = 8'h19,
    MIE_OP_ROTRC_ACC = 8'h1A,
    MIE_OP_PUSH = 8'h1B
  } mie_op_t;
  typedef enum logic [1:0] {MIE_ST_IDLE, MIE_ST_EXEC, MIE_ST_SLEEP} mie_state_t;
endpackage

/* File: rtl/mie_stack.sv */
// Return address stack for the instruction execute block
`timescale 1ns/1ps
`default_nettype none
module mie_stack #(
  parameter int DEPTH = 4,
  parameter int AW = 11
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic push,
  input wire logic pop,
  input wire logic [AW-1:0] push_data,
  output logic [AW-1:0] top_data,
  output logic [$clog2(DEPTH):0] level
);
  logic [AW-1:0] mem_q [DEPTH];
  logic [$clog2(DEPTH)-1:0] ptr_q;
  logic [$clog2(DEPTH):0] lvl_q;
  // Circular pointer; overflow overwrites the oldest entry
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ptr_q <= '0;
      lvl_q <= '0;
    end else if (push) begin
      ptr_q <= ptr_q + 1'b1;
      if (lvl_q != ($clog2(DEPTH)+1)'(DEPTH)) begin
        lvl_q <= lvl_q + 1'b1;
      end
    end else if (pop) begin
      ptr_q <= ptr_q - 1'b1;
      if (lvl_q != '0) begin
        lvl_q <= lvl_q - 1'b1;
      end
    end
  end
  // Storage write
  always_ff @(posedge pclk) begin
    if (push) begin
      mem_q[ptr_q] <= push_data;
    end
  end
  assign top_data = mem_q[ptr_q - 1'b1];
  assign level = lvl_q;
endmodule
`default_nettype wire

/* File: rtl/mie_core.sv */
// Instruction execute datapath with APB register access
// Contract
// - Complement inverts the byte; memory or accumulator target; only zero changes.
// - BCD low nibble adds 6 when above 9 or half carry; makes nibble carry.
// - BCD high nibble adds 6 plus nibble carry, sets carry; result to memory.
// - Decrement subtracts one; memory or accumulator target; only zero changes.
// - Increment adds one; memory or accumulator target; only zero changes.
// - Power-down stops execution and gates the clock, keeping all state.
// - Power-down clears watchdog and prescaler, sets sleep, clears expiry, bumps PC.
// - Jump loads the program counter from the instruction, no flags change.
// - Moves copy memory, accumulator or immediate without any flag change.
// - No-operation only advances the program counter by one.
// - OR combines accumulator with memory or immediate; only zero changes.
// - Plain return pops the PC, takes two cycles, no flag change.
// - Return with immediate pops the PC and loads the accumulator.
// - Interrupt return pops the PC and sets global interrupt enable.
// - Left rotate moves bit 7 into bit 0; no flags change.
// - Left rotate through carry: old carry into bit 0, bit 7 into carry.
// - Right rotate moves bit 0 into bit 7; no flags change.
// - Right rotate through carry: old carry into bit 7, bit 0 into carry.
// - Instruction cycle is four clocks; a program counter reload adds one.
//
// Local design decisions: the address map and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module mie_core
  import mie_pkg::*;
#(
  parameter int MEM_WORDS = 128,
  parameter int PC_W = 11,
  parameter int STACK_DEPTH = 4,
  parameter int WDT_W = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic wake,
  output logic busy,
  output logic sleeping,
  output logic core_clk_en
);
  mie_state_t state_q;
  logic [7:0] acc_q;
  logic [6:0] flags_q;
  logic [PC_W-1:0] pc_q;
  logic [7:0] dmem_q [MEM_WORDS];
  logic [1:0] phase_q;
  logic [1:0] cyc_left_q;
  logic [7:0] op_q;
  logic [6:0] addr_q;
  logic [7:0] imm_q;
  logic [PC_W-1:0] tgt_q;
  logic [WDT_W-1:0] wdt_q;
  logic [7:0] wdt_pre_q;
  logic [6:0] mem_ptr_q;
  logic [31:0] rdata_q;
  logic [7:0] m_rd;
  logic [PC_W-1:0] stk_top;
  logic [$clog2(STACK_DEPTH):0] stk_lvl;
  logic wr_en;
  logic rd_en;
  logic cmd_wr;
  logic done;
  // Execution results
  logic [7:0] res;
  logic res_to_acc;
  logic res_to_mem;
  logic [6:0] flags_d;
  logic [PC_W-1:0] pc_d;
  logic [1:0] ncyc;
  logic do_push;
  logic do_pop;
  logic clr_wdt;

  // Zero detect and flag update shared by the zero-affecting operations
  function automatic logic [6:0] set_z(input logic [6:0] f, input logic [7:0] v);
    logic [6:0] r;
    r = f;
    r[MIE_FLG_Z] = (v == 8'h00);
    return r;
  endfunction

  // APB decode; every access completes with no wait state
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;
  assign cmd_wr = wr_en && (paddr[7:0] == MIE_OFF_CMD) && (state_q == MIE_ST_IDLE);
  assign pready = 1'b1;
  assign pslverr = psel && penable && (paddr[31:8] != 24'h00_0000 || paddr[1:0] != 2'b00 ||
                   paddr[7:0] > MIE_OFF_SP);
  assign busy = (state_q == MIE_ST_EXEC);
  assign sleeping = (state_q == MIE_ST_SLEEP);
  assign core_clk_en = (state_q != MIE_ST_SLEEP);
  assign m_rd = dmem_q[addr_q];
  assign done = busy && (phase_q == MIE_PH_LAST);

  // Operation decode: result value, destination, flags, PC and stack effect
  always_comb begin
    logic [3:0] lo;
    logic [4:0] hi;
    logic nib_c;
    lo = 4'h0;
    hi = 5'h00;
    nib_c = 1'b0;
    res = 8'h00;
    res_to_acc = 1'b0;
    res_to_mem = 1'b0;
    flags_d = flags_q;
    pc_d = pc_q + 1'b1;
    ncyc = 2'd1;
    do_push = 1'b0;
    do_pop = 1'b0;
    clr_wdt = 1'b0;
    case (op_q)
      MIE_OP_IDLE: begin
        res = 8'h00;
      end
      MIE_OP_INV_MEM, MIE_OP_INV_ACC: begin
        res = ~m_rd;
        res_to_mem = (op_q == MIE_OP_INV_MEM);
        res_to_acc = (op_q == MIE_OP_INV_ACC);
        flags_d = set_z(flags_q, res);
      end
      MIE_OP_BCD: begin
        // Low nibble adjust and its internal carry
        if (acc_q[3:0] > 4'd9 || flags_q[MIE_FLG_HALF]) begin
          lo = acc_q[3:0] + 4'd6;
          nib_c = !flags_q[MIE_FLG_HALF]; // Nibble carry is the inverse of half carry
        end else begin
          lo = acc_q[3:0];
        end
        // High nibble adjust with the internal carry
        hi = {1'b0, acc_q[7:4]} + {4'h0, nib_c};
        if (hi > 5'd9 || flags_q[MIE_FLG_C]) begin
          hi = hi + 5'd6;
          flags_d[MIE_FLG_C] = 1'b1;
        end
        res = {hi[3:0], lo[3:0]};
        res_to_mem = 1'b1;
      end
      MIE_OP_SUB1_MEM, MIE_OP_SUB1_ACC: begin
        res = m_rd - 8'h01;
        res_to_mem = (op_q == MIE_OP_SUB1_MEM);
        res_to_acc = (op_q == MIE_OP_SUB1_ACC);
        flags_d = set_z(flags_q, res);
      end
      MIE_OP_INC_MEM, MIE_OP_INC_ACC: begin
        res = m_rd + 8'h01;
        res_to_mem = (op_q == MIE_OP_INC_MEM);
        res_to_acc = (op_q == MIE_OP_INC_ACC);
        flags_d = set_z(flags_q, res);
      end
      MIE_OP_SLEEP: begin
        flags_d[MIE_FLG_SLEEP] = 1'b1;
        flags_d[MIE_FLG_WDX] = 1'b0;
        clr_wdt = 1'b1;
      end
      MIE_OP_GOTO: begin
        pc_d = tgt_q;
        ncyc = 2'd2;
      end
      MIE_OP_COPY_A_M: begin
        res = m_rd;
        res_to_acc = 1'b1;
      end
      MIE_OP_COPY_M_A: begin
        res = acc_q;
        res_to_mem = 1'b1;
      end
      MIE_OP_COPY_A_X: begin
        res = imm_q;
        res_to_acc = 1'b1;
      end
      MIE_OP_OR_A_M, MIE_OP_OR_A_X, MIE_OP_OR_MEM: begin
        res = acc_q | ((op_q == MIE_OP_OR_A_X) ? imm_q : m_rd);
        res_to_mem = (op_q == MIE_OP_OR_MEM);
        res_to_acc = (op_q != MIE_OP_OR_MEM);
        flags_d = set_z(flags_q, res);
      end
      MIE_OP_POP, MIE_OP_POP_X, MIE_OP_IRET: begin
        pc_d = stk_top;
        do_pop = 1'b1;
        ncyc = 2'd2;
        if (op_q == MIE_OP_POP_X) begin
          res = imm_q;
          res_to_acc = 1'b1;
        end
        if (op_q == MIE_OP_IRET) begin
          flags_d[MIE_FLG_GIE] = 1'b1;
        end
      end
      MIE_OP_ROTL_MEM, MIE_OP_ROTL_ACC: begin
        res = {m_rd[6:0], m_rd[7]};
        res_to_mem = (op_q == MIE_OP_ROTL_MEM);
        res_to_acc = (op_q == MIE_OP_ROTL_ACC);
      end
      MIE_OP_ROTLC_MEM, MIE_OP_ROTLC_ACC: begin
        res = {m_rd[6:0], flags_q[MIE_FLG_C]};
        flags_d[MIE_FLG_C] = m_rd[7];
        res_to_mem = (op_q == MIE_OP_ROTLC_MEM);
        res_to_acc = (op_q == MIE_OP_ROTLC_ACC);
      end
      MIE_OP_ROTR_MEM, MIE_OP_ROTR_ACC: begin
        res = {m_rd[0], m_rd[7:1]};
        res_to_mem = (op_q == MIE_OP_ROTR_MEM);
        res_to_acc = (op_q == MIE_OP_ROTR_ACC);
      end
      MIE_OP_ROTRC_MEM, MIE_OP_ROTRC_ACC: begin
        res = {flags_q[MIE_FLG_C], m_rd[7:1]};
        flags_d[MIE_FLG_C] = m_rd[0];
        res_to_mem = (op_q == MIE_OP_ROTRC_MEM);
        res_to_acc = (op_q == MIE_OP_ROTRC_ACC);
      end
      MIE_OP_PUSH: begin
        do_push = 1'b1;
        pc_d = tgt_q;
        ncyc = 2'd2;
      end
      default: begin
        res = 8'h00;
      end
    endcase
    // A write that lands on memory word zero models a PC low reload
    if (res_to_mem && addr_q == 7'h00) begin
      ncyc = 2'd2;
    end
  end

  // Sequencer: idle, four-clock instruction cycles, power-down
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= MIE_ST_IDLE;
      phase_q <= 2'd0;
      cyc_left_q <= 2'd0;
    end else begin
      case (state_q)
        MIE_ST_IDLE: begin
          if (cmd_wr) begin
            state_q <= MIE_ST_EXEC;
            phase_q <= 2'd0;
            cyc_left_q <= 2'd0;
          end
        end
        MIE_ST_EXEC: begin
          phase_q <= phase_q + 2'd1;
          if (phase_q == MIE_PH_LAST) begin
            if (cyc_left_q == 2'd0) begin
              cyc_left_q <= (ncyc == 2'd1) ? 2'd0 : 2'd1;
              if (ncyc == 2'd1) begin
                state_q <= (op_q == MIE_OP_SLEEP) ? MIE_ST_SLEEP : MIE_ST_IDLE;
              end
            end else begin
              cyc_left_q <= 2'd0;
              state_q <= MIE_ST_IDLE;
            end
          end
        end
        MIE_ST_SLEEP: begin
          if (wake) begin
            state_q <= MIE_ST_IDLE;
          end
        end
        default: begin
          state_q <= MIE_ST_IDLE;
        end
      endcase
    end
  end

  // Effects commit once, at the end of the first instruction cycle
  logic commit;
  assign commit = done && (cyc_left_q == 2'd0);

  // Latched command fields
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_q <= 8'h00;
      addr_q <= 7'h00;
      imm_q <= 8'h00;
      tgt_q <= '0;
    end else if (cmd_wr) begin
      op_q <= pwdata[MIE_CMD_OP_LSB +: 8];
      addr_q <= pwdata[MIE_CMD_ADDR_LSB +: 7];
      imm_q <= pwdata[MIE_CMD_IMM_LSB +: 8];
      tgt_q <= pwdata[MIE_CMD_TGT_LSB +: PC_W];
    end
  end

  // Architectural state: accumulator, flags, program counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_q <= MIE_RST_ACC;
      flags_q <= MIE_RST_FLAGS;
      pc_q <= MIE_RST_PC;
    end else if (commit) begin
      if (res_to_acc) begin
        acc_q <= res;
      end
      flags_q <= flags_d;
      pc_q <= pc_d;
    end else if (!busy && wr_en) begin
      case (paddr[7:0])
        MIE_OFF_ACC: acc_q <= pwdata[7:0];
        MIE_OFF_FLAGS: flags_q <= pwdata[6:0];
        MIE_OFF_PC: pc_q <= pwdata[PC_W-1:0];
        default: acc_q <= acc_q;
      endcase
    end
  end

  // Data memory: execution write, or software write through the window
  always_ff @(posedge pclk) begin
    if (commit && res_to_mem) begin
      dmem_q[addr_q] <= res;
    end else if (!busy && wr_en && paddr[7:0] == MIE_OFF_MEM) begin
      dmem_q[mem_ptr_q] <= pwdata[7:0];
    end
  end

  // Memory window pointer, set by bits 14:8 of a write to the window or by bits 6:0 of a write to the status offset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_ptr_q <= 7'h00;
    end else if (wr_en && paddr[7:0] == MIE_OFF_MEM) begin
      mem_ptr_q <= pwdata[14:8];
    end else if (wr_en && paddr[7:0] == MIE_OFF_STAT) begin
      mem_ptr_q <= pwdata[6:0];
    end
  end

  // Watchdog counter and prescaler; power-down clears both
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdt_pre_q <= 8'h00;
      wdt_q <= '0;
    end else if (commit && clr_wdt) begin
      wdt_pre_q <= 8'h00;
      wdt_q <= '0;
    end else if (state_q != MIE_ST_SLEEP) begin
      wdt_pre_q <= wdt_pre_q + 8'h01;
      if (wdt_pre_q == 8'hFF) begin
        wdt_q <= wdt_q + 1'b1;
      end
    end
  end

  mie_stack #(
    .DEPTH(STACK_DEPTH),
    .AW(PC_W)
  ) u_stack (
    .pclk(pclk),
    .presetn(presetn),
    .push(commit && do_push),
    .pop(commit && do_pop),
    .push_data(pc_q + 1'b1),
    .top_data(stk_top),
    .level(stk_lvl)
  );

  // Registered read data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_q <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr[7:0])
        MIE_OFF_CMD: rdata_q <= {8'h00, imm_q, 1'b0, addr_q, op_q};
        MIE_OFF_ACC: rdata_q <= {24'h00_0000, acc_q};
        MIE_OFF_FLAGS: rdata_q <= {25'h000_0000, flags_q};
        MIE_OFF_PC: rdata_q <= {{(32-PC_W){1'b0}}, pc_q};
        MIE_OFF_MEM: rdata_q <= {24'h00_0000, dmem_q[mem_ptr_q]};
        MIE_OFF_STAT: rdata_q <= {29'h0000_0000, sleeping, busy, 1'b0};
        MIE_OFF_WDT: rdata_q <= {{(32-WDT_W){1'b0}}, wdt_q};
        MIE_OFF_SP: rdata_q <= {{(31-$clog2(STACK_DEPTH)){1'b0}}, stk_lvl};
        default: rdata_q <= 32'h0000_0000;
      endcase
    end
  end
  assign prdata = (rd_en && !pslverr) ? rdata_q : 32'h0000_0000; // Error reads return zero
endmodule
`default_nettype wire

/* File: tb/mie_core_assertions.sv */
// Port-level checks for the instruction execute block
`timescale 1ns/1ps
`default_nettype none
module mie_core_chk
  import mie_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic wake,
  input wire logic busy,
  input wire logic sleeping,
  input wire logic core_clk_en
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Command word accepted while the core is idle
  logic cmd_go;
  logic acc_ph;
  assign acc_ph = psel && penable;
  assign cmd_go = acc_ph && pwrite && paddr == 32'(MIE_OFF_CMD) && !busy && !sleeping;
  // Bus answer and error response
  pready_high_a: assert property (psel |-> pready) else $error("pready low in a transfer");
  slverr_unmapped_a: assert property (acc_ph && paddr > 32'h0000_001C |-> pslverr)
    else $error("no error on unmapped address");
  slverr_mapped_a: assert property (acc_ph && paddr <= 32'h0000_001C && paddr[1:0] == 2'b00
    |-> !pslverr) else $error("error on mapped address");
  err_rdata_a: assert property (acc_ph && !pwrite && pslverr |-> prdata == 32'h0000_0000)
    else $error("read data on error not zero");
  // Instruction cycle length: one or two cycles of four clocks
  busy_start_a: assert property (cmd_go |=> busy) else $error("command did not start");
  busy_min_a: assert property ($rose(busy) |-> busy[*4]) else $error("busy too short");
  busy_max_a: assert property ($rose(busy) |-> ##[4:8] !busy)
    else $error("busy too long");
  // Power-down gates the core clock and stops execution
  clk_gate_a: assert property (core_clk_en == !sleeping) else $error("clock gate wrong");
  sleep_quiet_a: assert property (sleeping |-> !busy) else $error("busy in power-down");
  sleep_entry_a: assert property ($rose(sleeping) |-> $past(busy))
    else $error("power-down without instruction");
endmodule
`default_nettype wire

/* File: tb/testbench.sv */
// Self-checking bench for the instruction execute block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) \
  begin \
    check_count++; \
    if ((g) !== (e)) begin \
      n_errors++; \
      $display("wrong value %s expected %h seen %h", nm, e, g); \
    end \
  end
module testbench
  import mie_pkg::*;
;
  typedef struct packed {
    mie_op_t op;
    logic [7:0] m, a, f, x, ea, em, ef;
  } mie_tb_row_t;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, wake = 1'b0;
  logic [31:0] paddr = 32'h0000_0000, pwdata = 32'h0000_0000, prdata, rdat;
  logic pready, pslverr, busy, sleeping, core_clk_en, serr;
  int n_errors = 0, check_count = 0;
  logic [10:0] pcx;
  logic [7:0] ex_ad = 8'h05;
  mie_tb_row_t r;
  mie_op_t rets [3] = '{MIE_OP_POP, MIE_OP_POP_X, MIE_OP_IRET};
  // Rows: op, mem in, acc in, flags in, immediate, acc out, mem out, flags out
  logic [63:0] rows [24] = '{64'h01FF_1201_0012_0005, 64'h020F_0004_00F0_0F00,
    64'h0377_9A04_009A_0005, 64'h0377_1502_0015_1B02, 64'h0377_2301_0023_8301,
    64'h0401_0003_0000_0007, 64'h0500_5504_00FF_0000, 64'h06FF_0000_0000_0004,
    64'h077F_0004_0080_7F00, 64'h0A00_3300_0000_0000, 64'h0B44_0000_0000_0000,
    64'h0C00_0007_A5A5_0007, 64'h0D00_0001_0000_0005, 64'h0E00_0F04_F0FF_0000,
    64'h0F22_1104_0011_3300, 64'h1381_0005_0000_0305, 64'h1480_0000_0001_8000,
    64'h1580_0000_0000_0001, 64'h1601_0001_0003_0100, 64'h1701_0001_0000_8001,
    64'h1802_0000_0001_0200, 64'h1901_0000_0000_0001, 64'h1A00_0001_0080_0000,
    64'h005A_3C47_003C_5A47};
  // 25 MHz clock
  always #20 pclk = ~pclk;
  mie_core i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .wake(wake), .busy(busy), .sleeping(sleeping),
    .core_clk_en(core_clk_en));
  // Prints the counts and the verdict, then ends the run
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // One APB transfer; read data and error are taken at the completing edge
  task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] wd);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= 32'(ad);
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdat = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] ad, input logic [31:0] wd);
    bus(1'b1, ad, wd);
  endtask
  task automatic rd(input logic [7:0] ad);
    bus(1'b0, ad, 32'h0000_0000);
  endtask
  // Issues one instruction on byte ex_ad (5 except for the word zero store) and counts the edges busy stays high
  task automatic exec(input mie_op_t op, input logic [10:0] t, input int cyc);
    int n;
    n = 0;
    wr(MIE_OFF_CMD, {5'h00, t, ex_ad, op});
    while (busy === 1'b1 && n < 20) begin
      @(posedge pclk);
      n++;
    end
    `CHK("cycles", cyc, n);
  endtask
  // Watchdog against a hung handshake
  initial begin
    repeat (6000) @(posedge pclk);
    n_errors++;
    stop_test();
  end
  // Main sequence
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    `CHK("clk_en", 1'b1, core_clk_en);
    rd(MIE_OFF_ACC);
    `CHK("acc reset", 32'(MIE_RST_ACC), rdat);
    rd(MIE_OFF_FLAGS);
    `CHK("flags reset", 32'(MIE_RST_FLAGS), rdat);
    rd(MIE_OFF_PC);
    `CHK("pc reset", 32'(MIE_RST_PC), rdat);
    $display("test reset done");
    foreach (rows[i]) begin
      r = mie_tb_row_t'(rows[i]);
      wr(MIE_OFF_STAT, 32'h0000_0005);
      wr(MIE_OFF_MEM, {16'h0000, 8'h05, r.m});
      wr(MIE_OFF_ACC, {24'h00_0000, r.a});
      wr(MIE_OFF_FLAGS, {24'h00_0000, r.f});
      exec(r.op, {3'b000, r.x}, 4);
      rd(MIE_OFF_ACC);
      `CHK("acc", r.ea, rdat[7:0]);
      rd(MIE_OFF_MEM);
      `CHK("mem", r.em, rdat[7:0]);
      rd(MIE_OFF_FLAGS);
      `CHK("flags", r.ef[6:0], rdat[6:0]);
    end
    $display("test table done");
    wr(MIE_OFF_FLAGS, 32'h0000_0007);
    exec(MIE_OP_GOTO, 11'h2A5, 8);
    rd(MIE_OFF_PC);
    `CHK("pc goto", 11'h2A5, rdat[10:0]);
    exec(MIE_OP_IDLE, 11'h000, 4);
    rd(MIE_OFF_PC);
    `CHK("pc idle", 11'h2A6, rdat[10:0]);
    pcx = 11'h2A6;
    foreach (rets[k]) begin
      exec(MIE_OP_PUSH, 11'h100, 8);
      exec(rets[k], 11'h05C, 8);
      pcx = pcx + 11'h001;
      rd(MIE_OFF_PC);
      `CHK("pc return", pcx, rdat[10:0]);
    end
    rd(MIE_OFF_ACC);
    `CHK("acc return", 8'h5C, rdat[7:0]);
    rd(MIE_OFF_FLAGS);
    `CHK("flags return", 7'h47, rdat[6:0]);
    $display("test branch done");
    wr(MIE_OFF_FLAGS, 32'h0000_0025);
    exec(MIE_OP_SLEEP, 11'h000, 4);
    `CHK("sleeping", 1'b1, sleeping);
    `CHK("clk_en", 1'b0, core_clk_en);
    rd(MIE_OFF_FLAGS);
    `CHK("flags sleep", 7'h15, rdat[6:0]);
    rd(MIE_OFF_PC);
    `CHK("pc sleep", pcx + 11'h001, rdat[10:0]);
    rd(MIE_OFF_WDT);
    `CHK("wdt", 16'h0000, rdat[15:0]);
    rd(MIE_OFF_ACC);
    `CHK("acc kept", 8'h5C, rdat[7:0]);
    wake <= 1'b1;
    repeat (8) if (sleeping === 1'b1) @(posedge pclk);
    wake <= 1'b0;
    `CHK("woken", 1'b0, sleeping);
    // A store to memory word zero stands for a PC low reload and takes two cycles
    ex_ad = 8'h00;
    exec(MIE_OP_COPY_M_A, 11'h000, 8);
    ex_ad = 8'h05;
    wr(MIE_OFF_STAT, 32'h0000_0000);
    rd(MIE_OFF_MEM);
    `CHK("mem word zero", 8'h5C, rdat[7:0]);
    $display("test power-down done");
    rd(8'h20);
    `CHK("slverr", 1'b1, serr);
    `CHK("unmapped data", 32'h0000_0000, rdat);
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(MIE_OFF_ACC);
    `CHK("acc second reset", 32'h0000_0000, rdat);
    $display("test error and reset done");
    stop_test();
  end
endmodule
bind mie_core mie_core_chk i_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .wake(wake), .busy(busy), .sleeping(sleeping),
  .core_clk_en(core_clk_en));
`default_nettype wire
